/* File: hdl/aism_regs.sv */
// Identification, status and config register bank with AHB-Lite slave
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module aism_regs
    import aism_pkg::*;
#(
    parameter logic [3:0] ID_FAMILY   = 4'hA,  // Arbitrary value
    parameter logic [7:0] ID_REVISION = 8'h10, // Arbitrary value
    parameter int         ADDR_W      = 32
) (
    // Clock and reset
    input  wire logic              I_CLK,
    input  wire logic              I_RSTN,
    // AHB-Lite slave
    input  wire logic              I_HSEL,
    input  wire logic [ADDR_W-1:0] I_HADDR,
    input  wire logic [1:0]        I_HTRANS,
    input  wire logic              I_HWRITE,
    input  wire logic [2:0]        I_HSIZE,
    input  wire logic [31:0]       I_HWDATA,
    input  wire logic              I_HREADY,
    output logic      [31:0]       O_HRDATA,
    output logic                   O_HREADYOUT,
    output logic                   O_HRESP,
    // Converter events
    input  wire logic              I_SPI_LOCK,
    input  wire logic              I_RESYNC_PIN,
    input  wire logic              I_RX_CRC_FAIL,
    input  wire logic [2:0]        I_NEW_DATA,
    input  wire logic [2:0]        I_DATA_TAKEN,
    // Sample formatting
    input  wire logic              I_SAMPLE_VALID,
    input  wire logic [23:0]       I_SAMPLE,
    output logic      [31:0]       O_SAMPLE_WORD,
    // Configuration outputs
    output logic      [1:0]        O_WORD_LEN,
    output logic                   O_CRC_ANSI,
    output logic                   O_RX_CRC_EN,
    output logic                   O_TIMEOUT_EN,
    output logic      [3:0]        O_DRDY_CFG,
    // Interrupt
    output logic                   O_IRQ
);
    typedef struct packed {
        logic [15:0]      cfg;
        logic             locked;
        logic             resync;
        logic             regmap_chg;
        logic             crc_err;
        logic             reset_flag;
        logic [2:0]       new_data;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic             resync_prev;
        logic             dp_act;
        logic             dp_write;
        logic             dp_hit;
        logic [2:0]       dp_idx;
        logic [31:0]      sample_word;
    } aism_state_t;

    aism_state_t s_q;
    aism_state_t s_d;

    logic        resync_lvl;
    logic        resync_evt;
    logic        ap_take;
    logic        ap_hit;
    logic        rd_status;
    logic        rd_irq;
    logic        wr_cfg;
    logic        wr_mask;
    logic [15:0] status_word;
    logic [31:0] rd_data;

    aism_crc_if crc_link ();

    aism_sync2 u_resync_sync (
        .I_CLK   (I_CLK),
        .I_RSTN  (I_RSTN),
        .i_pin   (I_RESYNC_PIN),
        .o_level (resync_lvl)
    );

    aism_regmap_crc u_regmap_crc (
        .I_CLK  (I_CLK),
        .I_RSTN (I_RSTN),
        .crc    (crc_link.mon)
    );

    // Sample placed into the selected output word format
    function automatic logic [31:0] fmt_sample(input logic [23:0] smp,
                                               input logic [1:0]  wl);
        logic [31:0] w;
        unique case (wl)
            WL_16:      w = {16'h0000, smp[23:8]};
            WL_24:      w = {8'h00, smp};
            WL_32_ZERO: w = {smp, 8'h00};
            WL_32_SIGN: w = {{8{smp[23]}}, smp};
        endcase
        return w;
    endfunction

    assign crc_link.data   = s_q.cfg;
    assign crc_link.ansi   = s_q.cfg[B_CRC_TYPE];
    assign crc_link.enable = s_q.cfg[B_REGCRC_EN];
    assign crc_link.rearm  = wr_cfg;

    assign resync_evt = resync_lvl && !s_q.resync_prev;

    // Address phase decode; zero wait states, so HREADY is always high
    assign ap_take = I_HSEL && I_HTRANS[HTRANS_ACT_BIT] && I_HREADY;
    assign ap_hit  = (I_HADDR[ADDR_W-1:5] == '0) && (I_HADDR[1:0] == 2'h0)
                     && (I_HADDR[4:2] <= IDX_IRQ_MASK);
    assign wr_cfg  = s_q.dp_act && s_q.dp_write && s_q.dp_hit
                     && s_q.dp_idx == IDX_CONFIG;
    assign wr_mask = s_q.dp_act && s_q.dp_write && s_q.dp_hit
                     && s_q.dp_idx == IDX_IRQ_MASK;
    assign rd_status = s_q.dp_act && !s_q.dp_write && s_q.dp_hit
                       && s_q.dp_idx == IDX_STATUS;
    assign rd_irq    = s_q.dp_act && !s_q.dp_write && s_q.dp_hit
                       && s_q.dp_idx == IDX_IRQ_STAT;

    always_comb begin
        status_word = '0;
        status_word[B_LOCK]      = s_q.locked;
        status_word[B_RESYNC]    = s_q.resync;
        status_word[B_REGMAP]    = s_q.regmap_chg;
        status_word[B_CRC_ERR]   = s_q.crc_err;
        status_word[B_CRC_TYPE]  = s_q.cfg[B_CRC_TYPE];
        status_word[B_RESET]     = s_q.reset_flag;
        status_word[B_WLEN_LSB+:2] = s_q.cfg[B_WLEN_LSB+:2];
        status_word[B_DRDY_LSB+:3] = s_q.new_data;
    end

    // Read mux in the data phase, so a write just before is seen
    always_comb begin
        rd_data = '0;
        if (s_q.dp_act && !s_q.dp_write && s_q.dp_hit) begin
            unique case (s_q.dp_idx)
                IDX_IDENT:    rd_data[15:0] = {ID_FAMILY, CHANNEL_COUNT,
                                               ID_REVISION};
                IDX_STATUS:   rd_data[15:0] = status_word;
                IDX_CONFIG:   rd_data[15:0] = s_q.cfg;
                IDX_IRQ_STAT: rd_data[IRQ_W-1:0] = s_q.irq_stat;
                IDX_IRQ_MASK: rd_data[IRQ_W-1:0] = s_q.irq_mask;
                default:      rd_data = '0;
            endcase
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.dp_act   = ap_take;
        s_d.dp_write = I_HWRITE;
        s_d.dp_hit   = ap_hit;
        s_d.dp_idx   = I_HADDR[4:2];
        s_d.locked   = I_SPI_LOCK;
        s_d.resync_prev = resync_lvl;

        // Reading status clears the resync, map CRC and input CRC flags; a new event wins
        if (rd_status) begin
            s_d.resync     = 1'b0;
            s_d.regmap_chg = 1'b0;
            s_d.crc_err    = 1'b0;
        end
        if (resync_evt) begin
            s_d.resync = 1'b1;
        end
        if (crc_link.changed) begin
            s_d.regmap_chg = 1'b1;
        end
        if (I_RX_CRC_FAIL && s_q.cfg[B_RXCRC_EN]) begin
            s_d.crc_err = 1'b1;
        end

        s_d.new_data = (s_q.new_data & ~I_DATA_TAKEN) | I_NEW_DATA;

        // Reserved bits are dropped, so they always read zero
        if (wr_cfg) begin
            s_d.cfg = I_HWDATA[15:0] & CONFIG_WR_MASK;
            if (!I_HWDATA[B_RESET]) begin
                s_d.reset_flag = 1'b0;
            end
        end
        if (wr_mask) begin
            s_d.irq_mask = I_HWDATA[IRQ_W-1:0];
        end

        if (rd_irq) begin
            s_d.irq_stat = '0;
        end
        s_d.irq_stat[IRQ_RESYNC]   = s_d.irq_stat[IRQ_RESYNC] | resync_evt;
        s_d.irq_stat[IRQ_REGMAP]   = s_d.irq_stat[IRQ_REGMAP]
                                     | crc_link.changed;
        s_d.irq_stat[IRQ_CRC_ERR]  = s_d.irq_stat[IRQ_CRC_ERR]
                                     | (I_RX_CRC_FAIL
                                        && s_q.cfg[B_RXCRC_EN]);
        s_d.irq_stat[IRQ_NEW_DATA] = s_d.irq_stat[IRQ_NEW_DATA]
                                     | (|I_NEW_DATA);

        if (I_SAMPLE_VALID) begin
            s_d.sample_word = fmt_sample(I_SAMPLE,
                                         s_q.cfg[B_WLEN_LSB+:2]);
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            s_q            <= '0;
            s_q.cfg        <= CONFIG_RST;
            s_q.reset_flag <= STATUS_RST[B_RESET];
        end else begin
            s_q <= s_d;
        end
    end

    assign O_HRDATA      = rd_data;
    assign O_HREADYOUT   = 1'b1;
    assign O_HRESP       = 1'b0;
    assign O_SAMPLE_WORD = s_q.sample_word;
    assign O_WORD_LEN    = s_q.cfg[B_WLEN_LSB+:2];
    assign O_CRC_ANSI    = s_q.cfg[B_CRC_TYPE];
    assign O_RX_CRC_EN   = s_q.cfg[B_RXCRC_EN];
    assign O_TIMEOUT_EN  = s_q.cfg[B_TIMEOUT];
    assign O_DRDY_CFG    = s_q.cfg[B_DRDY_LSB+:4];
    assign O_IRQ         = |(s_q.irq_stat & s_q.irq_mask);

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);

    a_ident_chcnt: assert property (
        (s_q.dp_act && !s_q.dp_write && s_q.dp_hit
         && s_q.dp_idx == IDX_IDENT)
        |-> O_HRDATA[ID_CHCNT_LSB+:4] == CHANNEL_COUNT)
        else $error("channel count field wrong");

    a_lock_bit: assert property (
        I_SPI_LOCK ##1 rd_status |-> O_HRDATA[B_LOCK])
        else $error("lock bit does not follow interface");

    a_resync_flag: assert property (
        resync_evt |=> status_word[B_RESYNC])
        else $error("resync did not set flag");

    a_regmap_gate: assert property (
        !s_q.cfg[B_REGCRC_EN] [*3] |-> !crc_link.changed)
        else $error("map CRC flagged while disabled");

    a_rx_crc_gate: assert property (
        (I_RX_CRC_FAIL && !s_q.cfg[B_RXCRC_EN] && !s_q.crc_err)
        |=> !s_q.crc_err)
        else $error("input CRC error set while disabled");

    a_crc_err_set: assert property (
        (I_RX_CRC_FAIL && s_q.cfg[B_RXCRC_EN]) |=> status_word[B_CRC_ERR])
        else $error("input CRC error lost");

    a_mirror_fields: assert property (
        rd_status |-> O_HRDATA[B_CRC_TYPE] == O_CRC_ANSI
        && O_HRDATA[B_WLEN_LSB+:2] == O_WORD_LEN)
        else $error("status copy differs from config");

    a_reset_clear: assert property (
        (wr_cfg && !I_HWDATA[B_RESET]) |=> !status_word[B_RESET])
        else $error("reset flag not cleared");

    a_sign_extend: assert property (
        (I_SAMPLE_VALID && O_WORD_LEN == WL_32_SIGN)
        |=> O_SAMPLE_WORD[31:24] == {8{$past(I_SAMPLE[23])}})
        else $error("sign extension wrong");

    a_new_data: assert property (
        I_NEW_DATA[0] |=> status_word[B_DRDY_LSB])
        else $error("new data flag lost");

    a_timeout_cfg: assert property (
        wr_cfg |=> O_TIMEOUT_EN == $past(I_HWDATA[B_TIMEOUT]))
        else $error("timeout enable not written");

    a_lock_clear: assert property (
        !I_SPI_LOCK ##1 rd_status |-> !O_HRDATA[B_LOCK])
        else $error("lock bit set while unlocked");

    a_resync_clear: assert property (
        (rd_status && !resync_evt) |=> !s_q.resync)
        else $error("resync flag not cleared by read");

    a_regmap_set: assert property (
        crc_link.changed |=> status_word[B_REGMAP])
        else $error("map CRC change not flagged");

    a_regmap_clear: assert property (
        (rd_status && !crc_link.changed) |=> !s_q.regmap_chg)
        else $error("map CRC flag not cleared by read");

    a_crc_err_clear: assert property (
        (rd_status && !(I_RX_CRC_FAIL && s_q.cfg[B_RXCRC_EN]))
        |=> !s_q.crc_err)
        else $error("input CRC flag not cleared by read");

    a_crc_type_wr: assert property (
        wr_cfg |=> O_CRC_ANSI == $past(I_HWDATA[B_CRC_TYPE]))
        else $error("CRC type not written");

    a_reset_sticky: assert property (
        !s_q.reset_flag |=> !s_q.reset_flag)
        else $error("reset flag set without reset");

    a_wlen_write: assert property (
        wr_cfg |=> O_WORD_LEN == $past(I_HWDATA[B_WLEN_LSB+:2]))
        else $error("word length not written");

    a_data_taken: assert property (
        (I_DATA_TAKEN[0] && !I_NEW_DATA[0]) |=> !status_word[B_DRDY_LSB])
        else $error("new data flag not cleared");

    a_regcrc_wr: assert property (
        wr_cfg |=> s_q.cfg[B_REGCRC_EN] == $past(I_HWDATA[B_REGCRC_EN]))
        else $error("map CRC enable not written");

    a_rx_en_wr: assert property (
        wr_cfg |=> O_RX_CRC_EN == $past(I_HWDATA[B_RXCRC_EN]))
        else $error("input CRC enable not written");
endmodule

/* File: hdl/aism_pkg.sv */
// Shared constants for the identification, status and mode register bank
package aism_pkg;

    // Register indices; byte address is four times the index
    localparam logic [2:0]  IDX_IDENT      = 3'h0;
    localparam logic [2:0]  IDX_STATUS     = 3'h1;
    localparam logic [2:0]  IDX_CONFIG     = 3'h2;
    localparam logic [2:0]  IDX_IRQ_STAT   = 3'h3;
    localparam logic [2:0]  IDX_IRQ_MASK   = 3'h4;

    // Identification fields
    localparam int          ID_CHCNT_LSB   = 8;
    localparam logic [3:0]  CHANNEL_COUNT  = 4'h3;

    // Status and config shared bit positions
    localparam int          B_LOCK         = 15;
    localparam int          B_RESYNC       = 14;
    localparam int          B_REGMAP       = 13;
    localparam int          B_CRC_ERR      = 12;
    localparam int          B_REGCRC_EN    = 13;
    localparam int          B_RXCRC_EN     = 12;
    localparam int          B_CRC_TYPE     = 11;
    localparam int          B_RESET        = 10;
    localparam int          B_WLEN_LSB     = 8;
    localparam int          B_TIMEOUT      = 4;
    localparam int          B_DRDY_LSB     = 0;

    // Reset values
    localparam logic [15:0] STATUS_RST     = 16'h0500;
    localparam logic [15:0] CONFIG_RST     = 16'h0510;
    // Writable config bits; reserved 15:14 and 7:5 are not stored
    localparam logic [15:0] CONFIG_WR_MASK = 16'h3F1F;

    // Word length codes
    localparam logic [1:0]  WL_16          = 2'h0;
    localparam logic [1:0]  WL_24          = 2'h1;
    localparam logic [1:0]  WL_32_ZERO     = 2'h2;
    localparam logic [1:0]  WL_32_SIGN     = 2'h3;

    // CRC polynomials and seed
    localparam logic [15:0] POLY_CCITT     = 16'h1021;
    localparam logic [15:0] POLY_ANSI      = 16'h8005;
    localparam logic [15:0] CRC_SEED       = 16'hFFFF;

    // Interrupt event bits
    localparam int          IRQ_W          = 4;
    localparam int          IRQ_RESYNC     = 0;
    localparam int          IRQ_REGMAP     = 1;
    localparam int          IRQ_CRC_ERR    = 2;
    localparam int          IRQ_NEW_DATA   = 3;

    // AHB transfer type bit that marks an active transfer
    localparam int          HTRANS_ACT_BIT = 1;

endpackage

/* File: hdl/aism_crc_if.sv */
// Link between the register bank and its register-map CRC monitor
`timescale 1ns/1ps
interface aism_crc_if;
    logic [15:0] data;
    logic        ansi;
    logic        enable;
    logic        rearm;
    logic        changed;

    modport mon  (input  data, ansi, enable, rearm, output changed);
    modport bank (output data, ansi, enable, rearm, input  changed);
endinterface

/* File: hdl/aism_sync2.sv */
// Two-flop synchroniser for a pin from outside the clock domain
`timescale 1ns/1ps
module aism_sync2 (
    // Clock and reset
    input  wire logic I_CLK,
    input  wire logic I_RSTN,
    // Pin and synchronised level
    input  wire logic i_pin,
    output logic      o_level
);
    typedef struct packed {
        logic meta;
        logic level;
    } aism_sync_t;

    aism_sync_t s_q;
    aism_sync_t s_d;

    always_comb begin
        s_d.meta  = i_pin;
        s_d.level = s_q.meta;
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_level = s_q.level;
endmodule

/* File: hdl/aism_regmap_crc.sv */
// Register-map CRC monitor flagging an unexpected change of the checksum
`timescale 1ns/1ps
module aism_regmap_crc
    import aism_pkg::*;
(
    // Clock and reset
    input  wire logic I_CLK,
    input  wire logic I_RSTN,
    // Bank side
    aism_crc_if.mon   crc
);
    typedef struct packed {
        logic [15:0] crc_ref;
        logic        valid;
        logic        changed;
    } aism_crc_t;

    aism_crc_t c_q;
    aism_crc_t c_d;
    logic [15:0] crc_now;

    function automatic logic [15:0] crc16(input logic [15:0] data,
                                          input logic [15:0] poly);
        logic [15:0] r;
        r = CRC_SEED;
        for (int i = 15; i >= 0; i--) begin
            if (r[15] ^ data[i]) begin
                r = {r[14:0], 1'b0} ^ poly;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction

    always_comb begin
        crc_now   = crc16(crc.data, crc.ansi ? POLY_ANSI : POLY_CCITT);
        c_d       = c_q;
        c_d.changed = 1'b0;
        c_d.crc_ref = crc_now;
        // Reference is rebuilt after a legal write or a re-enable
        c_d.valid = crc.enable && !crc.rearm;
        if (crc.enable && c_q.valid && !crc.rearm
            && crc_now != c_q.crc_ref) begin
            c_d.changed = 1'b1;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    assign crc.changed = c_q.changed;
endmodule

/* File: tb/aism_conv_model.sv */
// Behavioural model of the converter side that raises status events
`timescale 1ns/1ps
module aism_conv_model (
    // Clock
    input  wire logic        I_CLK,
    // Event and sample outputs
    output logic             o_lock,
    output logic             o_resync,
    output logic             o_crc_fail,
    output logic      [2:0]  o_new,
    output logic      [2:0]  o_taken,
    output logic             o_valid,
    output logic      [23:0] o_sample
);
    initial begin
        o_lock     = 1'b0;
        o_resync   = 1'b0;
        o_crc_fail = 1'b0;
        o_new      = 3'h0;
        o_taken    = 3'h0;
        o_valid    = 1'b0;
        o_sample   = 24'h0;
    end

    task automatic set_lock(input logic v);
        @(posedge I_CLK);
        o_lock <= v;
    endtask

    // One-cycle event: 0 resync, 1 CRC fail, 2 new data, 3 taken, 4 sample
    task automatic pulse(input int k, input logic [2:0] ch,
                         input logic [23:0] s);
        @(posedge I_CLK);
        case (k)
            0: o_resync <= 1'b1;
            1: o_crc_fail <= 1'b1;
            2: o_new <= ch;
            3: o_taken <= ch;
            default: begin
                o_valid  <= 1'b1;
                o_sample <= s;
            end
        endcase
        @(posedge I_CLK);
        o_resync   <= 1'b0;
        o_crc_fail <= 1'b0;
        o_new      <= 3'h0;
        o_taken    <= 3'h0;
        o_valid    <= 1'b0;
        // Released bus shows garbage, not the last sample
        o_sample   <= ~s;
    endtask
endmodule

/* File: tb/aism_regs_tb_top.sv */
// Self-checking bench for the identification, status and config bank
`timescale 1ns/1ps
module aism_regs_tb_top
    import aism_pkg::*;
;
    localparam logic [3:0] ID_FAM = 4'hA; // Arbitrary value
    localparam logic [7:0] ID_REV = 8'h10; // Arbitrary value
    localparam int         LIMIT  = 20000;

    logic        I_CLK;
    logic        I_RSTN;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        lock;
    logic        resync;
    logic        crc_fail;
    logic [2:0]  new_data;
    logic [2:0]  taken;
    logic        s_valid;
    logic [23:0] sample;
    logic [31:0] s_word;
    logic [1:0]  word_len;
    logic        crc_ansi;
    logic        rx_en;
    logic        to_en;
    logic [3:0]  drdy_cfg;
    logic        irq;
    int          fail_count;
    int          checked;
    int          cyc = 0;
    logic [31:0] cfg;
    logic [31:0] rd;

    aism_regs #(.ID_FAMILY(ID_FAM), .ID_REVISION(ID_REV), .ADDR_W(32))
    aism_regs_inst (
        .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
        .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
        .O_HREADYOUT(hready), .O_HRESP(hresp), .I_SPI_LOCK(lock),
        .I_RESYNC_PIN(resync), .I_RX_CRC_FAIL(crc_fail),
        .I_NEW_DATA(new_data), .I_DATA_TAKEN(taken),
        .I_SAMPLE_VALID(s_valid), .I_SAMPLE(sample),
        .O_SAMPLE_WORD(s_word), .O_WORD_LEN(word_len),
        .O_CRC_ANSI(crc_ansi), .O_RX_CRC_EN(rx_en),
        .O_TIMEOUT_EN(to_en), .O_DRDY_CFG(drdy_cfg), .O_IRQ(irq)
    );

    aism_conv_model aism_conv_model_inst (
        .I_CLK(I_CLK), .o_lock(lock), .o_resync(resync),
        .o_crc_fail(crc_fail), .o_new(new_data), .o_taken(taken),
        .o_valid(s_valid), .o_sample(sample)
    );

    initial begin
        I_CLK = 1'b0;
        forever #20 I_CLK = ~I_CLK;
    end

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge I_CLK) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Single word transfer; waits on the slave's ready, never a fixed count
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] wd);
        @(posedge I_CLK);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        hsize  <= 3'h2;
        do @(posedge I_CLK); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge I_CLK); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    function automatic logic [31:0] fmt(input logic [1:0] wl,
                                        input logic [23:0] s);
        case (wl)
            WL_16:      return {16'h0, s[23:8]};
            WL_24:      return {8'h0, s};
            WL_32_ZERO: return {s, 8'h0};
            default:    return {{8{s[23]}}, s};
        endcase
    endfunction

    initial begin
        {hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
        {fail_count, checked} = '0;
        I_RSTN = 1'b0;
        repeat (16) @(posedge I_CLK);
        I_RSTN <= 1'b1;
        rd_chk(32'h0, {16'h0, ID_FAM, CHANNEL_COUNT, ID_REV});
        chk(hresp, 1'b0);
        xfer(1'b1, 32'h0, 32'h0000FFFF);
        rd_chk(32'h0, {16'h0, ID_FAM, CHANNEL_COUNT, ID_REV});
        rd_chk(32'h4, 32'h00000500);
        rd_chk(32'h8, 32'h00000510);
        chk({word_len, to_en, crc_ansi, rx_en, irq}, 6'h18);
        rd_chk(32'h20, 32'h0);
        aism_conv_model_inst.set_lock(1'b1);
        repeat (3) @(posedge I_CLK);
        rd_chk(32'h4, 32'h00008500);
        xfer(1'b1, 32'h8, 32'h00000110);
        rd_chk(32'h4, 32'h00008100);
        aism_conv_model_inst.pulse(0, 3'h0, 24'h0);
        repeat (5) @(posedge I_CLK);
        rd_chk(32'h4, 32'h0000C100);
        rd_chk(32'h4, 32'h00008100);
        for (int i = 0; i < 4; i++) begin
            cfg = {18'h0, i[1], i[0], i[0], 1'b1, i[1:0], 3'h0, ~i[0],
                   i[1:0], i[1:0]};
            xfer(1'b1, 32'h8, cfg);
            rd_chk(32'h8, cfg);
            chk({word_len, crc_ansi, rx_en, to_en, drdy_cfg},
                {i[1:0], i[0], i[0], ~i[0], i[1:0], i[1:0]});
            aism_conv_model_inst.pulse(1, 3'h0, 24'h0);
            @(posedge I_CLK);
            rd_chk(32'h4, {16'h8000 | (i[0] << 12) | (i[0] << 11)
                           | (i[1:0] << 8)});
            aism_conv_model_inst.pulse(4, 3'h0, 24'h812345);
            repeat (2) @(posedge I_CLK);
            chk(s_word, fmt(i[1:0], 24'h812345));
        end
        xfer(1'b1, 32'h8, 32'h00000110);
        for (int n = 0; n < 3; n++) begin
            aism_conv_model_inst.pulse(2, 3'(1 << n), 24'h0);
            rd_chk(32'h4, 32'h00008100 | (1 << n));
            aism_conv_model_inst.pulse(3, 3'(1 << n), 24'h0);
            rd_chk(32'h4, 32'h00008100);
        end
        xfer(1'b0, 32'hC, 32'h0);
        aism_conv_model_inst.pulse(0, 3'h0, 24'h0);
        repeat (5) @(posedge I_CLK);
        chk(irq, 1'b0);
        xfer(1'b1, 32'h10, 32'h1);
        repeat (2) @(posedge I_CLK);
        chk(irq, 1'b1);
        rd_chk(32'hC, 32'h1);
        repeat (2) @(posedge I_CLK);
        chk(irq, 1'b0);
        // Second reset in mid-run must restore the flag and defaults
        I_RSTN <= 1'b0;
        repeat (2) @(posedge I_CLK);
        I_RSTN <= 1'b1;
        repeat (2) @(posedge I_CLK);
        rd_chk(32'h4, 32'h00008500);
        rd_chk(32'h8, 32'h00000510);
        rd_chk(32'h10, 32'h0);
        complete_run();
    end
endmodule
